// ==== hra_regs.svh ====
`ifndef HRA_REGS_SVH
`define HRA_REGS_SVH

// core clock period
`define HRA_CLK_NS       10

// strobe low time: covers access time and least pulse width
`define HRA_ACT_NS       85
// strobes high between cycles, data still held on writes
`define HRA_REC_NS       20
// least low time of the device reset pin
`define HRA_RST_NS       85

`define HRA_ACT_CYC      ((`HRA_ACT_NS + `HRA_CLK_NS - 1) / `HRA_CLK_NS)
`define HRA_REC_CYC      ((`HRA_REC_NS + `HRA_CLK_NS - 1) / `HRA_CLK_NS)
`define HRA_RST_CYC      ((`HRA_RST_NS + `HRA_CLK_NS - 1) / `HRA_CLK_NS)

// last bit index of the 64-bit key and of the 64-bit transfer
`define HRA_LAST_BIT     6'h3f
`define HRA_FIRST_BIT    6'h00
`define HRA_CNT_ZERO     4'h0

// inactive level of every active-low strobe and of the pin enable
`define HRA_IDLE_LVL     1'b1
`define HRA_ACT_LVL      1'b0

// comparison value; arbitrary default, set to the device's own value
`define HRA_UNLOCK_DEF   64'h0f1e_2d3c_4b5a_6978

`endif

// ==== hra_pkg.sv ====
package hra_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACT,
        ST_REC,
        ST_RST
    } hra_state_e;

    typedef enum logic [1:0] {
        PH_SYNC,
        PH_KEY,
        PH_XFER
    } hra_phase_e;

    typedef struct packed {
        hra_state_e  st;
        hra_phase_e  phase;
        logic [3:0]  cnt;
        logic [5:0]  idx;
        logic        wr;
        logic [16:0] addr;
        logic [63:0] data;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dq0_out;
        logic        dq0_oe_n;
        logic        rst_pin_n;
        logic        busy;
        logic        done;
    } hra_regs_s;

endpackage : hra_pkg

// ==== hra_host.sv ====
// Notes on behaviour
// - unlock needs 64 consecutive writes with key bits on data_line_zero.
// - sequence opens with one read using chip enable and output enable.
// - host uses one scratch address for all unlock writes.
// - key sent least significant bit first, most significant last.
// - transfer walks bit 0 of register 0 to bit 7 of register 7.
// - host moves clock registers as whole bytes only.
`timescale 1ns/10ps
`include "hra_regs.svh"
`default_nettype none

module hra_host
    import hra_pkg::*;
#(
    // arbitrary default; must equal the device's comparison value
    parameter logic [63:0] UNLOCK_PATTERN = `HRA_UNLOCK_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic        write_mode,
    input  wire logic [63:0] wdata,
    input  wire logic [16:0] scratch_addr,
    input  wire logic        abort,
    input  wire logic        supply_ok,
    output logic      [63:0] rdata,
    output logic             busy,
    output logic             done,
    output logic      [16:0] addr,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    input  wire logic        dq0_in,
    output logic             dq0_out,
    output logic             dq0_oe_n,
    output logic             rst_pin_n
);

    localparam logic [3:0] ACT_LAST = 4'(`HRA_ACT_CYC - 1);
    localparam logic [3:0] REC_LAST = 4'(`HRA_REC_CYC - 1);
    localparam logic [3:0] RST_LAST = 4'(`HRA_RST_CYC - 1);

    hra_regs_s  s;
    hra_regs_s  next_s;
    hra_phase_e nph;
    logic [5:0] nidx;
    logic       nwr_cyc;
    logic       nbit;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s  = s;
        nph     = s.phase;
        nidx    = s.idx;
        nwr_cyc = 1'b0;
        nbit    = 1'b0;
        next_s.done = 1'b0;
        unique case (s.st)
            ST_IDLE: begin
                // no cycle while supply is low: device would ignore it
                if (start && supply_ok) begin
                    next_s.busy  = 1'b1;
                    next_s.wr    = write_mode;
                    // all eight registers move as whole bytes every time
                    next_s.data  = wdata;
                    next_s.addr  = scratch_addr;
                    next_s.phase = PH_SYNC;
                    next_s.idx   = `HRA_FIRST_BIT;
                    next_s.st    = ST_ACT;
                    next_s.cnt   = ACT_LAST;
                    // opening read resets the device pointer
                    next_s.ce_n  = `HRA_ACT_LVL;
                    next_s.oe_n  = `HRA_ACT_LVL;
                end
            end
            ST_ACT: begin
                if (s.cnt == `HRA_CNT_ZERO) begin
                    next_s.ce_n = `HRA_IDLE_LVL;
                    next_s.oe_n = `HRA_IDLE_LVL;
                    next_s.we_n = `HRA_IDLE_LVL;
                    next_s.st   = ST_REC;
                    next_s.cnt  = REC_LAST;
                    // sampled at the end of the read strobe
                    if (s.phase == PH_XFER && !s.wr) begin
                        next_s.data[s.idx] = dq0_in;
                    end
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            ST_REC: begin
                if (s.cnt == `HRA_CNT_ZERO) begin
                    // data held through recovery, released here or by abort
                    next_s.dq0_oe_n = `HRA_IDLE_LVL;
                    unique case (s.phase)
                        PH_SYNC: begin
                            nph  = PH_KEY;
                            nidx = `HRA_FIRST_BIT;
                        end
                        PH_KEY: begin
                            if (s.idx == `HRA_LAST_BIT) begin
                                nph  = PH_XFER;
                                nidx = `HRA_FIRST_BIT;
                            end else begin
                                nidx = s.idx + 6'h1;
                            end
                        end
                        PH_XFER: begin
                            nidx = s.idx + 6'h1;
                        end
                    endcase
                    if (s.phase == PH_XFER && s.idx == `HRA_LAST_BIT) begin
                        // device falls back to memory; next use unlocks anew
                        next_s.st   = ST_IDLE;
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                    end else begin
                        // key cycles are always writes, never reads
                        nwr_cyc = (nph == PH_KEY) || s.wr;
                        // key goes lsb first; transfer walks bits upward
                        nbit = (nph == PH_KEY) ? UNLOCK_PATTERN[nidx]
                                               : s.data[nidx];
                        next_s.phase = nph;
                        next_s.idx   = nidx;
                        next_s.st    = ST_ACT;
                        next_s.cnt   = ACT_LAST;
                        next_s.ce_n  = `HRA_ACT_LVL;
                        if (nwr_cyc) begin
                            next_s.we_n     = `HRA_ACT_LVL;
                            next_s.dq0_oe_n = `HRA_ACT_LVL;
                            next_s.dq0_out  = nbit;
                        end else begin
                            next_s.oe_n = `HRA_ACT_LVL;
                        end
                    end
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            ST_RST: begin
                if (s.cnt == `HRA_CNT_ZERO) begin
                    next_s.rst_pin_n = `HRA_IDLE_LVL;
                    next_s.st        = ST_IDLE;
                    next_s.busy      = 1'b0;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        // abort pulls the device reset pin; effective only if the
        // reset-ignore bit was left at zero in the day register
        if (abort && s.busy && s.st != ST_RST) begin
            next_s.st        = ST_RST;
            next_s.cnt       = RST_LAST;
            next_s.ce_n      = `HRA_IDLE_LVL;
            next_s.oe_n      = `HRA_IDLE_LVL;
            next_s.we_n      = `HRA_IDLE_LVL;
            next_s.dq0_oe_n  = `HRA_IDLE_LVL;
            next_s.rst_pin_n = `HRA_ACT_LVL;
            next_s.done      = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s           <= '0;
            s.st        <= ST_IDLE;
            s.phase     <= PH_SYNC;
            s.ce_n      <= `HRA_IDLE_LVL;
            s.oe_n      <= `HRA_IDLE_LVL;
            s.we_n      <= `HRA_IDLE_LVL;
            s.dq0_oe_n  <= `HRA_IDLE_LVL;
            s.rst_pin_n <= `HRA_IDLE_LVL;
        end else begin
            s <= next_s;
        end
    end

    assign rdata     = s.data;
    assign busy      = s.busy;
    assign done      = s.done;
    assign addr      = s.addr;
    assign ce_n      = s.ce_n;
    assign oe_n      = s.oe_n;
    assign we_n      = s.we_n;
    assign dq0_out   = s.dq0_out;
    assign dq0_oe_n  = s.dq0_oe_n;
    assign rst_pin_n = s.rst_pin_n;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence seq_strobe;
        (ce_n == 1'b0) [*8] ##1 ce_n == 1'b0;
    endsequence

    sequence seq_release;
        ce_n && oe_n && we_n;
    endsequence

    property p_sync_read;
        $rose(busy) |-> !ce_n && !oe_n && we_n && s.phase == PH_SYNC;
    endproperty
    a_sync_read: assert property (p_sync_read)
        else $error("sequence did not open with a read");

    property p_key_no_read;
        s.phase == PH_KEY |-> oe_n;
    endproperty
    a_key_no_read: assert property (p_key_no_read)
        else $error("read issued during key phase");

    property p_key_bit;
        s.phase == PH_KEY && !we_n |-> dq0_out == UNLOCK_PATTERN[s.idx] && !dq0_oe_n;
    endproperty
    a_key_bit: assert property (p_key_bit)
        else $error("wrong key bit on data line");

    property p_scratch;
        busy && $past(busy) && !ce_n |-> addr == $past(addr);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("address moved during sequence");

    property p_xfer_bit;
        s.phase == PH_XFER && !we_n |-> dq0_out == s.data[s.idx];
    endproperty
    a_xfer_bit: assert property (p_xfer_bit)
        else $error("wrong transfer bit on data line");

    property p_strobe_len;
        $fell(ce_n) && !abort |-> seq_strobe ##1 seq_release or
            ##[0:8] !rst_pin_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe low time off");

    property p_no_contention;
        !dq0_oe_n |-> oe_n;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives while device outputs");

    property p_abort;
        abort && busy && s.st != ST_RST |=> !rst_pin_n && ce_n && oe_n && we_n && dq0_oe_n;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not reach reset pin");

    property p_one_strobe;
        !(oe_n == 1'b0 && we_n == 1'b0);
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("read and write strobes both low");

    property p_done_end;
        $rose(done) |-> !busy && s.phase == PH_XFER && s.idx == `HRA_LAST_BIT;
    endproperty
    a_done_end: assert property (p_done_end)
        else $error("done without full transfer");

    property p_key_writes;
        s.phase == PH_KEY && !ce_n |-> !we_n;
    endproperty
    a_key_writes: assert property (p_key_writes)
        else $error("key cycle was not a write");

    property p_data_hold;
        $rose(we_n) && rst_pin_n |-> !dq0_oe_n;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data released with the strobe");

endmodule : hra_host

`default_nettype wire

// ==== hra_dev_model.sv ====
`timescale 1ns/10ps
`include "hra_regs.svh"
`default_nettype none

module hra_dev_model #(
    parameter logic [63:0] KEY = `HRA_UNLOCK_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        powered,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        dq,
    input  wire logic        rst_pin_n,
    output logic             dq_out,
    output logic      [63:0] regs,
    output logic      [7:0]  mem_wr
);
    // unused bits read zero; hour mode, pm and oscillator bits kept
    // bench leaves the oscillator stopped, so no counting is modelled
    localparam logic [63:0] KEEP = 64'hff1f_3f37_bf7f_7fff;
    logic [1:0]  ph;
    logic        miss;
    logic [5:0]  ptr;
    logic        cyc;
    logic        wr;
    logic        bit_in;
    logic        tgl;
    logic [63:0] shadow;
    ////////////////////////////////////////////////////////////
    // released line toggles so a stale bit never reads as data
    assign dq_out = (ph == 2'h2 && !ce_n && !oe_n) ? regs[ptr] : tgl;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ph <= 2'h0;
            miss <= 1'b0;
            ptr <= 6'h00;
            cyc <= 1'b0;
            wr <= 1'b0;
            bit_in <= 1'b0;
            tgl <= 1'b0;
            shadow <= 64'h0;
            regs <= 64'h0;
            mem_wr <= 8'h00;
        end else begin
            tgl <= ~tgl;
            cyc <= powered && !ce_n;
            if (!ce_n) begin
                wr <= !we_n;
                bit_in <= dq;
            end
            if (!rst_pin_n && !regs[36]) begin
                ph <= 2'h0;
            end else if (cyc && ce_n) begin
                if (wr && ph != 2'h2) begin
                    mem_wr <= mem_wr + 8'h01;
                end
                if (ph == 2'h2) begin
                    shadow[ptr] <= wr ? bit_in : shadow[ptr];
                    ptr <= ptr + 6'h01;
                    if (ptr == 6'h3f) begin
                        ph <= 2'h0;
                        if (wr) begin
                            regs <= {bit_in, shadow[62:0]} & KEEP;
                        end
                    end
                end else if (!wr) begin
                    ph <= 2'h1;
                    ptr <= 6'h00;
                    miss <= 1'b0;
                end else if (ph == 2'h1 && !miss) begin
                    if (bit_in == KEY[ptr]) begin
                        ptr <= ptr + 6'h01;
                        ph <= (ptr == 6'h3f) ? 2'h2 : 2'h1;
                    end else begin
                        miss <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : hra_dev_model

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        core_clk;
    logic        nrst;
    logic        start;
    logic        write_mode;
    logic        abort;
    logic        supply_ok;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic [63:0] regs;
    logic [7:0]  mem_wr;
    logic [16:0] addr;
    logic        busy;
    logic        done;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq0_in;
    logic        dq0_out;
    logic        dq0_oe_n;
    logic        rst_pin_n;
    int          n_fail;
    int          cmp_count;
    ////////////////////////////////////////////////////////////
    hra_host u_dut (.core_clk(core_clk), .nrst(nrst), .start(start),
        .write_mode(write_mode), .wdata(wdata), .scratch_addr(17'h1fff0),
        .abort(abort), .supply_ok(supply_ok), .rdata(rdata), .busy(busy),
        .done(done), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq0_in(dq0_in), .dq0_out(dq0_out), .dq0_oe_n(dq0_oe_n),
        .rst_pin_n(rst_pin_n));
    // pulled-up data line when the host lets go
    hra_dev_model u_dev (.core_clk(core_clk), .nrst(nrst), .powered(supply_ok),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq(dq0_oe_n ? 1'b1 : dq0_out), .rst_pin_n(rst_pin_n),
        .dq_out(dq0_in), .regs(regs), .mem_wr(mem_wr));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // a second start at cycle 100 must change nothing
    task automatic run_seq(input logic wm, input logic [63:0] wd, output int n);
        n = 0;
        @(posedge core_clk);
        #1 write_mode = wm;
        wdata = wd;
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            #1 n++;
            start = (n == 100);
        end
    endtask : run_seq

    task automatic t_xfer(input logic wm, input logic [63:0] wd, input logic [63:0] exp);
        int n;
        logic [7:0] m0;
        m0 = mem_wr;
        run_seq(wm, wd, n);
        chk(64'(n), 64'd1419, "latency");
        chk(64'(8'(mem_wr - m0)), 64'd64, "memory writes");
        chk(64'(addr), 64'h1fff0, "scratch address");
        chk(wm ? regs : rdata, exp, "clock data");
    endtask : t_xfer

    task automatic t_abort;
        int n;
        int lows;
        logic saw_done;
        n = 0;
        lows = 0;
        saw_done = 1'b0;
        @(posedge core_clk);
        #1 write_mode = 1'b1;
        wdata = '1;
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        repeat (800) @(posedge core_clk);
        #1 abort = 1'b1;
        while (busy === 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
            lows += (rst_pin_n === 1'b0);
            saw_done |= done;
        end
        abort = 1'b0;
        chk({busy, saw_done}, 2'b00, "abort end");
        chk(64'(lows), 64'd9, "reset pin width");
        chk(regs, 64'h991f_3f27_bf7f_7fa5, "data kept");
    endtask : t_abort

    task automatic t_nopower;
        supply_ok = 1'b0;
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 chk({busy, ce_n}, 2'b01, "start under low supply");
        supply_ok = 1'b1;
    endtask : t_nopower
    ////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #(20000 * 10);
        n_fail++;
        conclude();
    end

    initial begin
        n_fail = 0;
        cmp_count = 0;
        nrst = 1'b0;
        start = 1'b0;
        write_mode = 1'b0;
        abort = 1'b0;
        supply_ok = 1'b1;
        wdata = 64'h0;
        repeat (2) @(posedge core_clk);
        #1 nrst = 1'b1;
        chk({ce_n, oe_n, we_n, dq0_oe_n, rst_pin_n, busy, done}, 7'h7c, "idle");
        t_nopower();
        // zero bits set on purpose, reset-ignore bit left clear
        t_xfer(1'b1, 64'h99ff_ffef_ffff_ffa5, 64'h991f_3f27_bf7f_7fa5);
        t_xfer(1'b0, 64'h0, 64'h991f_3f27_bf7f_7fa5);
        t_abort();
        t_xfer(1'b0, 64'h0, 64'h991f_3f27_bf7f_7fa5);
        conclude();
    end
endmodule : tb_top

`default_nettype wire
